// ==== cbtp_map.vh ====
// constants for the capture buffer with test pattern generator
// assumes plain verilog includers; definitions only
`ifndef CBTP_MAP_VH
`define CBTP_MAP_VH
`define CBTP_CTRL_ADDR      4'hF
`define CBTP_CTRL_RESET     16'h0000
`define CBTP_SIZE_HI_BIT    15
`define CBTP_SIZE_LO_BIT    14
`define CBTP_AUTO_STOP_BIT  13
`define CBTP_DUAL_LANE_BIT  12
`define CBTP_PATTERN_BIT    11
`define CBTP_STAT_FULL_BIT  0
`define CBTP_STAT_EMPTY_BIT 1
`define CBTP_STAT_FROZE_BIT 2
`define CBTP_BASE_DEPTH     13'h0200
`define CBTP_READ_LATENCY   2'h2
`endif

// ==== cbtp_fifo.v ====
// small first-word-first-out store for the readout path
// assumes one clock, synchronous active high reset
`timescale 1ns/10ps
module cbtp_fifo
#(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW    = 3
)
(
   input  wire             clk,
   input  wire             reset,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg [AW-1:0]    wp_ff;
   reg [AW-1:0]    rp_ff;
   reg [AW:0]      cnt_ff;
   wire            push;
   wire            pop;

   assign in_ready  = (cnt_ff != DEPTH[AW:0]);
   assign out_valid = (cnt_ff != {(AW+1){1'b0}});
   assign out_data  = mem_ff[rp_ff];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk)
   begin
      if (push)
         mem_ff[wp_ff] <= in_data;
   end

   always @(posedge clk)
   begin
      if (reset)
      begin
         wp_ff  <= {AW{1'b0}};
         rp_ff  <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wp_ff <= (wp_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_ff + 1'b1;
         if (pop)
            rp_ff <= (rp_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_ff + 1'b1;
         if (push & ~pop)
            cnt_ff <= cnt_ff + 1'b1;
         else if (pop & ~push)
            cnt_ff <= cnt_ff - 1'b1;
      end
   end
endmodule // cbtp_fifo

// ==== cbtp_capture_buffer.v ====
// capture buffer: stores samples on clk, reads out on a sampled read clock
// assumes sample clock is clk; read clock, write and read enables are async pins
//
// Functional notes
// [RL1] pattern only on first lane unless dual lane bit 12 is set
// [RL2] pattern enable bit 11 replaces converter data and drives over range
// [RL3] pattern mode holds over range high until empty flag rises
// [RL4] single lane pattern 01,02,03,04,FE,FD,FC,FB; second lane floats
// [RL5] dual lane: second lane 01,03,FE,FC; first lane 02,04,FD,FB
// [RL6] pattern bytes change together with the data ready strobe
// [RL7] size field bits 15:14 selects 512, 1024, 2048 or 4096 bytes
// [RL8] reading starts only after the whole depth is written and full set
// [RL9] never write and read the buffer at the same time
// [RL10] empty flag rises after last byte; further reads refused
// [RL11] capture starts only while empty; synced write enable clears empty
// [RL12] synced read enable clears full; reads only while full was high
// [RL13] reset clears full, sets empty, aborts transfers, rewinds pointers
// [RL14] samples stored at the sample clock only while write enabled
// [RL15] write pointer wraps over oldest data unless auto stop bit 13
// [RL16] bytes shift out on rising read clock edges while read enabled; once the read has started, the code keeps shifting even if read enable drops
// [RL17] buffered data on first lane only, or both lanes in dual mode
// [RL18] dual lane: oldest byte to second lane, next to first lane
// [RL19] write and read together: write wins, buffer freezes until reset
// [RL20] first byte and strobe on third rising read clock edge after enable
// [RL21] over range set by out of range samples, cleared at empty
// [RL22] write enable synced output shows when capture really started
// [RL23] cross-domain enables and clocks pass two flip-flop synchronisers
`include "cbtp_map.vh"
`timescale 1ns/10ps
module cbtp_capture_buffer
#(
   parameter MAX_DEPTH = 4096,
   parameter PTR_W     = 12,
   parameter FIFO_DEP  = 8
)
(
   input  wire        clk,
   input  wire        reset,
   input  wire [3:0]  reg_addr,
   input  wire        reg_write,
   input  wire [15:0] reg_wdata,
   output wire [15:0] reg_rdata,
   input  wire [7:0]  sample_data,
   input  wire        sample_over_range,
   input  wire        write_enable_in,
   input  wire        read_enable_in,
   input  wire        read_clock,
   output wire [7:0]  first_byte_lane,
   output wire [7:0]  second_byte_lane,
   output wire        second_lane_oe_n,
   output wire        data_ready_strobe,
   output wire        over_range_flag,
   output wire        full_flag,
   output wire        empty_flag,
   output wire        write_enable_synced
);
   localparam ST_IDLE = 3'h0;
   localparam ST_CAPT = 3'h1;
   localparam ST_FULL = 3'h2;
   localparam ST_READ = 3'h3;
   localparam ST_FROZ = 3'h4;

   ////////////////////////////////////////////////////////////////////////
   // control register and synchronisers
   reg  [15:0]      ctrl_ff;
   reg  [1:0]       wen_sync_ff;
   reg  [1:0]       ren_sync_ff;
   reg  [2:0]       rclk_sync_ff;
   wire             wen_s;
   wire             ren_s;
   wire             rd_rise;
   wire             rd_fall;
   wire             dual;
   wire             ptn;
   wire [12:0]      depth;

   assign wen_s   = wen_sync_ff[1];
   assign ren_s   = ren_sync_ff[1];
   assign rd_rise = rclk_sync_ff[1] & ~rclk_sync_ff[2];
   assign rd_fall = ~rclk_sync_ff[1] & rclk_sync_ff[2];
   assign dual    = ctrl_ff[`CBTP_DUAL_LANE_BIT];
   assign ptn     = ctrl_ff[`CBTP_PATTERN_BIT];
   // 512 shifted by the size code
   assign depth   = `CBTP_BASE_DEPTH << ctrl_ff[`CBTP_SIZE_HI_BIT:`CBTP_SIZE_LO_BIT]; // RL7

   always @(posedge clk)
   begin
      if (reset)
      begin
         ctrl_ff      <= `CBTP_CTRL_RESET;
         wen_sync_ff  <= 2'h0;
         ren_sync_ff  <= 2'h0;
         rclk_sync_ff <= 3'h0;
      end
      else
      begin
         if (reg_write && reg_addr == `CBTP_CTRL_ADDR)
            ctrl_ff <= reg_wdata;
         wen_sync_ff  <= {wen_sync_ff[0], write_enable_in}; // RL23
         ren_sync_ff  <= {ren_sync_ff[0], read_enable_in}; // RL23
         // third stage only feeds the edge detector, never the raw pin
         rclk_sync_ff <= {rclk_sync_ff[1:0], read_clock}; // RL23
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // capture state
   reg  [2:0]       state_ff;
   reg  [PTR_W-1:0] wr_ptr_ff;
   reg  [12:0]      wcnt_ff;
   reg              full_ff;
   reg              empty_ff;
   reg              ovr_ff;
   reg  [7:0]       mem_ff [0:MAX_DEPTH-1];
   wire             wr_en;
   wire             read_done;
   wire             start_read;

   // a write is allowed in the capture state even when a read collides
   assign wr_en      = (state_ff == ST_CAPT) & wen_s; // RL14 RL19
   assign start_read = (state_ff == ST_CAPT || state_ff == ST_FULL) & full_ff & ren_s & ~wen_s; // RL8 RL9 RL12

   always @(posedge clk)
   begin
      if (wr_en)
         mem_ff[wr_ptr_ff] <= sample_data; // RL14
   end

   always @(posedge clk)
   begin
      if (reset)
      begin
         state_ff  <= ST_IDLE; // RL13
         wr_ptr_ff <= {PTR_W{1'b0}};
         wcnt_ff   <= 13'h0000;
         full_ff   <= 1'b0;
         empty_ff  <= 1'b1;
         ovr_ff    <= 1'b0;
      end
      else
      begin
         if (read_done)
            ovr_ff <= 1'b0; // RL21 RL3
         else if (ptn && state_ff != ST_IDLE)
            ovr_ff <= 1'b1; // RL2 RL3
         else if (wr_en && sample_over_range)
            ovr_ff <= 1'b1; // RL21
         case (state_ff)
            ST_IDLE:
            begin
               // ren alone is ignored here: the captured data is gone
               if (wen_s)
               begin
                  state_ff  <= ST_CAPT; // RL11
                  empty_ff  <= 1'b0; // RL11
                  wr_ptr_ff <= {PTR_W{1'b0}};
                  wcnt_ff   <= 13'h0000;
               end
            end
            ST_CAPT:
            begin
               if (wen_s && ren_s)
                  state_ff <= ST_FROZ; // RL19
               else if (wen_s)
               begin
                  wr_ptr_ff <= (wr_ptr_ff == depth[PTR_W-1:0] - 1'b1 || depth == 13'h1000 &&
                                &wr_ptr_ff) ? {PTR_W{1'b0}} : wr_ptr_ff + 1'b1; // RL15
                  if (wcnt_ff == depth - 1'b1)
                  begin
                     full_ff <= 1'b1;
                     if (ctrl_ff[`CBTP_AUTO_STOP_BIT])
                        state_ff <= ST_FULL; // RL15
                  end
                  if (wcnt_ff != depth)
                     wcnt_ff <= wcnt_ff + 1'b1;
               end
               else if (start_read)
               begin
                  state_ff <= ST_READ;
                  full_ff  <= 1'b0; // RL12
               end
            end
            ST_FULL:
            begin
               if (wen_s && ren_s)
                  state_ff <= ST_FROZ; // RL19
               else if (start_read)
               begin
                  state_ff <= ST_READ;
                  full_ff  <= 1'b0; // RL12
               end
            end
            ST_READ:
            begin
               if (wen_s)
                  state_ff <= ST_FROZ; // RL19
               else if (read_done)
               begin
                  state_ff <= ST_IDLE;
                  empty_ff <= 1'b1; // RL10
               end
            end
            ST_FROZ:
               state_ff <= ST_FROZ; // RL19
            default:
               state_ff <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fetch from memory or pattern generator into the fifo
   reg  [PTR_W-1:0] rd_ptr_ff;
   reg  [12:0]      fcnt_ff;
   reg              half_ff;
   reg  [7:0]       hold_ff;
   reg  [7:0]       ptn_byte;
   wire [7:0]       src_byte;
   wire             f_ready;
   wire             f_step;
   wire [15:0]      f_out;
   wire             f_valid;
   wire             f_pop;

   always @*
   begin
      case (fcnt_ff[2:0])
         3'h0: ptn_byte = 8'h01;
         3'h1: ptn_byte = 8'h02;
         3'h2: ptn_byte = 8'h03;
         3'h3: ptn_byte = 8'h04;
         3'h4: ptn_byte = 8'hFE;
         3'h5: ptn_byte = 8'hFD;
         3'h6: ptn_byte = 8'hFC;
         default: ptn_byte = 8'hFB;
      endcase
   end

   // even pattern index lands on second lane in dual mode, giving 01/02 pairs
   assign src_byte = ptn ? ptn_byte : mem_ff[rd_ptr_ff]; // RL2 RL4 RL5
   assign f_step   = (state_ff == ST_READ) & f_ready & (fcnt_ff != depth);

   always @(posedge clk)
   begin
      if (reset || state_ff != ST_READ)
      begin
         // oldest sample sits at the write pointer after any wrap
         rd_ptr_ff <= wr_ptr_ff; // RL13 RL15
         fcnt_ff   <= 13'h0000;
         half_ff   <= 1'b0;
         hold_ff   <= 8'h00;
      end
      else if (f_step)
      begin
         rd_ptr_ff <= (rd_ptr_ff == depth[PTR_W-1:0] - 1'b1 || depth == 13'h1000 &&
                       &rd_ptr_ff) ? {PTR_W{1'b0}} : rd_ptr_ff + 1'b1;
         fcnt_ff   <= fcnt_ff + 1'b1;
         if (dual)
            half_ff <= ~half_ff;
         if (dual && !half_ff)
            hold_ff <= src_byte; // RL18
      end
   end

   cbtp_fifo
   #(
      .WIDTH (16),
      .DEPTH (FIFO_DEP),
      .AW    (3)
   )
   u_fifo
   (
      .clk       (clk),
      .reset     (reset || state_ff != ST_READ),
      .in_data   ({(dual ? hold_ff : 8'h00), src_byte}),
      .in_valid  (f_step && !(dual && !half_ff)),
      .in_ready  (f_ready),
      .out_data  (f_out),
      .out_valid (f_valid),
      .out_ready (f_pop)
   );

   ////////////////////////////////////////////////////////////////////////
   // output stage on read clock edges
   reg  [1:0]       lat_ff;
   reg  [12:0]      ocnt_ff;
   reg  [7:0]       lane1_ff;
   reg  [7:0]       lane2_ff;
   reg              strobe_ff;
   wire [12:0]      words;

   assign words     = dual ? {1'b0, depth[12:1]} : depth; // RL17
   assign f_pop     = (state_ff == ST_READ) & rd_rise & (lat_ff == `CBTP_READ_LATENCY) & f_valid; // RL16
   assign read_done = (state_ff == ST_READ) & (ocnt_ff == words);

   always @(posedge clk)
   begin
      if (reset || state_ff != ST_READ)
      begin
         lat_ff    <= 2'h0;
         ocnt_ff   <= 13'h0000;
         strobe_ff <= 1'b0;
         if (reset)
         begin
            lane1_ff <= 8'h00;
            lane2_ff <= 8'h00;
         end
      end
      else
      begin
         if (rd_rise && lat_ff != `CBTP_READ_LATENCY)
            lat_ff <= lat_ff + 1'b1; // RL20
         if (f_pop)
         begin
            lane1_ff  <= f_out[7:0]; // RL1 RL17
            lane2_ff  <= f_out[15:8]; // RL18 RL5
            strobe_ff <= 1'b1; // RL6
            ocnt_ff   <= ocnt_ff + 1'b1;
         end
         else if (rd_fall)
            strobe_ff <= 1'b0;
      end
   end

   assign first_byte_lane     = lane1_ff;
   assign second_byte_lane    = lane2_ff;
   assign second_lane_oe_n    = ~dual; // RL1 RL4
   assign data_ready_strobe   = strobe_ff;
   assign over_range_flag     = ovr_ff;
   assign full_flag           = full_ff;
   assign empty_flag          = empty_ff;
   assign write_enable_synced = wen_s; // RL22
   assign reg_rdata           = (reg_addr == `CBTP_CTRL_ADDR) ?
                                {ctrl_ff[15:11], 8'h00, state_ff == ST_FROZ, empty_ff, full_ff} : 16'h0000;
endmodule // cbtp_capture_buffer

// ==== cbtp_capture_buffer_properties.sv ====
// port checker for the capture buffer
// assumes one clock domain and a synchronous reset
`timescale 1ns/10ps
module cbtp_capture_buffer_properties
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [3:0]  reg_addr,
   input wire logic        reg_write,
   input wire logic [15:0] reg_wdata,
   input wire logic        write_enable_in,
   input wire logic [7:0]  first_byte_lane,
   input wire logic        second_lane_oe_n,
   input wire logic        data_ready_strobe,
   input wire logic        over_range_flag,
   input wire logic        full_flag,
   input wire logic        empty_flag,
   input wire logic        write_enable_synced
);
   default clocking cbtp_dc @(posedge clk);
   endclocking
   default disable iff (reset);
   logic [15:0] ctrl_ff;
   logic [12:0] fill_ff;
   logic [12:0] depth_w;
   ////////////////////////////////////////
   always @(posedge clk)
   begin
      if (reset)
         ctrl_ff <= 16'h0000;
      else if (reg_write && reg_addr == 4'hF)
         ctrl_ff <= reg_wdata;
   end
   // edges spent filling; held at zero while idle
   always @(posedge clk)
   begin
      if (reset || empty_flag)
         fill_ff <= 13'h0000;
      else if (!full_flag)
         fill_ff <= fill_ff + 13'h0001;
   end
   assign depth_w = 13'h0200 << ctrl_ff[15:14];
   ////////////////////////////////////////
   sequence s_cap_go;
      $rose(write_enable_synced) && empty_flag;
   endsequence
   sequence s_word;
      $rose(data_ready_strobe);
   endsequence
   AST_RESET_STATE: assert property ($fell(reset) |-> empty_flag && !full_flag)
      else $error("flags wrong after reset");
   AST_WEN_SYNC: assert property (!$past(reset) && !$past(reset, 2) |->
      write_enable_synced == $past(write_enable_in, 2)) else $error("synced enable off");
   AST_EMPTY_CLEAR: assert property (s_cap_go |=> !empty_flag)
      else $error("empty kept after start");
   AST_FULL_DEPTH: assert property ($rose(full_flag) |-> fill_ff == depth_w)
      else $error("full at wrong depth");
   AST_WORD_IN_READ: assert property (s_word |-> !full_flag && !$past(empty_flag))
      else $error("word outside a read");
   AST_PAT_OVR: assert property ((s_word and ctrl_ff[11]) |-> over_range_flag)
      else $error("over range low in pattern");
   AST_OVR_CLEAR: assert property ($fell(over_range_flag) |-> empty_flag)
      else $error("over range cleared early");
   AST_LANE2_FLOAT: assert property (!ctrl_ff[12] |-> second_lane_oe_n)
      else $error("second lane driven");
   AST_LANE_STROBE: assert property ($changed(first_byte_lane) |-> s_word)
      else $error("lane moved without strobe");
endmodule // cbtp_capture_buffer_properties
bind cbtp_capture_buffer cbtp_capture_buffer_properties cbtp_capture_buffer_properties_inst
   (.clk, .reset, .reg_addr, .reg_write, .reg_wdata, .write_enable_in, .first_byte_lane,
    .second_lane_oe_n, .data_ready_strobe, .over_range_flag, .full_flag, .empty_flag, .write_enable_synced);

// ==== cbtp_reader_model.sv ====
// reader model: free running read clock, read enable, strobe latch
// assumes the bench raises want_read and watches got_pulse on clk
`timescale 1ns/10ps
module cbtp_reader_model
(
   input  wire logic       clk,
   input  wire logic       want_read,
   input  wire logic [7:0] first_byte_lane,
   input  wire logic [7:0] second_byte_lane,
   input  wire logic       data_ready_strobe,
   output logic            read_clock,
   output logic            read_enable_in = 1'b0,
   output logic [15:0]     got_word,
   output logic            got_pulse = 1'b0
);
   logic strobe_ff = 1'b0;
   initial
   begin
      read_clock = 1'b0;
      forever #24 read_clock = ~read_clock;
   end
   // enable moves only on the read clock, as a real reader would
   always @(posedge read_clock)
      read_enable_in <= want_read;
   always @(posedge clk)
   begin
      strobe_ff <= data_ready_strobe;
      got_pulse <= data_ready_strobe && !strobe_ff;
      got_word <= {second_byte_lane, first_byte_lane};
   end
endmodule // cbtp_reader_model

// ==== cbtp_capture_buffer_tb_top.sv ====
// self-checking bench for the capture buffer
// assumes the reader model makes the read clock
`timescale 1ns/10ps
module cbtp_capture_buffer_tb_top;
   logic        clk;
   logic        reset;
   logic [3:0]  reg_addr;
   logic        reg_write;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic [7:0]  sample_data;
   logic        sample_over_range;
   logic        write_enable_in;
   logic        want_read;
   logic        read_enable_in;
   logic        read_clock;
   logic [7:0]  first_byte_lane;
   logic [7:0]  second_byte_lane;
   logic        second_lane_oe_n;
   logic        data_ready_strobe;
   logic        over_range_flag;
   logic        full_flag;
   logic        empty_flag;
   logic        write_enable_synced;
   logic [15:0] got_word;
   logic        got_pulse;
   logic [16:0] exp_q[$];
   int          err_total;
   int          total_checks;
   logic [15:0] ctl_tab[8] = '{16'h2000, 16'h3000, 16'h2800, 16'h3800, 16'h7000, 16'hB800, 16'hF000,
                               16'h1000};
   ////////////////////////////////////////
   cbtp_capture_buffer cbtp_capture_buffer_inst (.clk, .reset, .reg_addr, .reg_write, .reg_wdata,
      .reg_rdata, .sample_data, .sample_over_range, .write_enable_in, .read_enable_in, .read_clock,
      .first_byte_lane, .second_byte_lane, .second_lane_oe_n, .data_ready_strobe, .over_range_flag,
      .full_flag, .empty_flag, .write_enable_synced);
   cbtp_reader_model cbtp_reader_model_inst (.clk, .want_read, .first_byte_lane, .second_byte_lane,
      .data_ready_strobe, .read_clock, .read_enable_in, .got_word, .got_pulse);
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic close_out;
      begin
         $display("errors %0d checks %0d", err_total, total_checks);
         if (err_total == 0 && total_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      begin
         total_checks++;
         if (got !== exp)
         begin
            err_total++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
         end
      end
   endtask
   task automatic check_word(input logic [15:0] got, input logic oe_n);
      logic [16:0] e;
      logic        had;
      begin
         had = exp_q.size() > 0;
         e = had ? exp_q.pop_front() : 17'h00000;
         total_checks++;
         if (!had || got[7:0] !== e[7:0] || oe_n !== !e[16] || (e[16] && got[15:8] !== e[15:8]))
         begin
            err_total++;
            $display("BAD %0t word %h expected %h", $time, got, e);
         end
      end
   endtask
   always @(posedge clk)
      if (got_pulse === 1'b1)
         check_word(got_word, second_lane_oe_n);
   task automatic wreg(input logic [15:0] v);
      begin
         @(negedge clk);
         reg_addr = 4'hF;
         reg_wdata = v;
         reg_write = 1'b1;
         @(negedge clk);
         reg_write = 1'b0;
      end
   endtask
   // first store lands four edges after the enable; without auto stop the
   // store keeps wrapping, so only the newest depth samples survive
   task automatic capture(input logic [15:0] ctl);
      logic [7:0] b[$];
      logic [7:0] pat[8];
      int         n;
      begin
         pat = '{8'h01, 8'h02, 8'h03, 8'h04, 8'hFE, 8'hFD, 8'hFC, 8'hFB};
         n = 512 << ctl[15:14];
         wreg(ctl);
         write_enable_in = 1'b1;
         for (int i = 0; i < n + 6; i++)
         begin
            sample_data = 8'($urandom);
            sample_over_range = (i == 9);
            if (i >= 3 && (i < n + 3 || !ctl[13]))
               b.push_back(ctl[11] ? pat[(i - 3) % 8] : sample_data);
            @(negedge clk);
         end
         write_enable_in = 1'b0;
         sample_over_range = 1'b0;
         // synced enable lingers two edges and stores the last sample twice
         if (!ctl[13])
         begin
            b.push_back(sample_data);
            b.push_back(sample_data);
         end
         while (b.size() > n)
            b.delete(0);
         // let the synced write enable drop before any read is asked for
         repeat (4) @(negedge clk);
         check_val({14'h0000, full_flag, empty_flag}, 16'h0002);
         check_val({15'h0000, over_range_flag}, 16'h0001);
         for (int k = 0; k < n; k += ctl[12] ? 2 : 1)
            exp_q.push_back(ctl[12] ? {1'b1, b[k], b[k + 1]} : {9'h000, b[k]});
      end
   endtask
   task automatic readout;
      begin
         want_read = 1'b1;
         for (int t = 0; t < 60000 && empty_flag !== 1'b1; t++)
            @(negedge clk);
         want_read = 1'b0;
         repeat (40) @(negedge clk);
         check_val({14'h0000, full_flag, empty_flag}, 16'h0001);
         check_val({15'h0000, over_range_flag}, 16'h0000);
         check_val(16'(exp_q.size()), 16'h0000);
      end
   endtask
   ////////////////////////////////////////
   initial
   begin
      #380000;
      err_total++;
      close_out();
   end
   initial
   begin
      reset = 1'b1;
      reg_addr = 4'hF;
      reg_write = 1'b0;
      reg_wdata = 16'h0000;
      sample_data = 8'h00;
      sample_over_range = 1'b0;
      write_enable_in = 1'b0;
      want_read = 1'b0;
      err_total = 0;
      total_checks = 0;
      void'($urandom(32'h7535f374));
      repeat (6) @(negedge clk);
      reset = 1'b0;
      reg_addr = 4'h3;
      #1;
      check_val(reg_rdata, 16'h0000);
      @(negedge clk);
      reg_addr = 4'hF;
      #1;
      check_val(reg_rdata, 16'h0002);
      wreg(16'hF800);
      check_val(reg_rdata, 16'hF802);
      foreach (ctl_tab[j])
      begin
         capture(ctl_tab[j]);
         readout();
      end
      // a write raised in mid-read must freeze the buffer until reset
      capture(16'h2000);
      want_read = 1'b1;
      repeat (300) @(negedge clk);
      write_enable_in = 1'b1;
      repeat (20) @(negedge clk);
      check_val(reg_rdata & 16'h0004, 16'h0004);
      write_enable_in = 1'b0;
      want_read = 1'b0;
      repeat (40) @(negedge clk);
      reset = 1'b1;
      repeat (6) @(negedge clk);
      reset = 1'b0;
      exp_q.delete();
      #1;
      check_val(reg_rdata, 16'h0002);
      close_out();
   end
endmodule // cbtp_capture_buffer_tb_top
